// File: design/capture_compare_map.vh
// Register map, field positions, reset values and mode codes of the
// capture/compare unit. Definitions only.
`ifndef CAPTURE_COMPARE_MAP_VH
`define CAPTURE_COMPARE_MAP_VH

// Word indices; byte address is four times the index
`define CTRL_INDEX 8'h17
`define VALUE_LOW_INDEX 8'h15
`define VALUE_HIGH_INDEX 8'h16
`define FLAG_INDEX 8'h0c
`define STATUS_INDEX 8'h18

`define CTRL_RESET 8'h00
`define CTRL_WRITE_MASK 8'h3f
`define FLAG_BIT 2

`define MODE_OFF 4'h0
`define MODE_CAP_FALL 4'h4
`define MODE_CAP_RISE 4'h5
`define MODE_CAP_RISE4 4'h6
`define MODE_CAP_RISE16 4'h7
`define MODE_CMP_SET 4'h8
`define MODE_CMP_CLEAR 4'h9
`define MODE_CMP_SOFT 4'ha
`define MODE_CMP_SPECIAL 4'hb

`define PRESCALE_4_LAST 4'h3
`define PRESCALE_16_LAST 4'hf

`endif

// File: design/capture_compare_unit.v
// Capture/compare unit: 16-bit value register, control register, event
// flag, Avalon-MM slave for software access.
// Assumes the timebase count and the port write strobe come from logic
// on clk; the event pin is asynchronous and is synchronised here.
//
// What this block does
// - 16-bit value held as low and high byte, both readable and writable.
// - Mode 0000 switches the unit off and clears the prescaler counter.
// - Codes 0100-0111 capture on fall, rise, 4th rise, 16th rise.
// - Code 1000 drives pin high, 1001 low on match; both set flag.
// - Code 1010 sets only the flag on match, pin unchanged.
// - Code 1011 sets flag, resets timebase, starts conversion if enabled.
// - Codes 11xx select PWM; bits 5-4 hold duty low bits, else ignored.
// - Control bits 7-6 read as zero.
// - Capture loads the full 16-bit timebase count into the value.
// - Each capture sets flag bit 2; it stays until software clears it.
// - A new capture overwrites an unread old value.
// - Port writes reaching the pin act as events and may capture.
// - Mode change may set the flag falsely; software masks then clears.
// - Prescaler counter cleared when off or not in capture mode.
// - Direct prescale switch keeps the counter; software goes via off.
// - Compare checks value against timebase every cycle, acts on equal.
// - Every compare match sets the flag, whatever sub-mode.
// - Writing zero to control forces the compare output latch low.
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ns
`include "capture_compare_map.vh"

module capture_compare_unit #(
	parameter VALUE_WIDTH = 16
) (
	input wire clk,
	input wire rst_b,
	// Avalon-MM slave
	input wire [7:0] address,
	input wire read,
	input wire write,
	input wire [31:0] writedata,
	input wire [3:0] byteenable,
	output reg [31:0] readdata,
	output reg waitrequest,
	output reg [1:0] response,
	// Timebase and pin
	input wire [VALUE_WIDTH-1:0] timebase_sixteen_count,
	input wire unit_event_pin,
	input wire converter_enabled,
	output reg compare_output,
	output reg timebase_reset,
	output reg conversion_start,
	output reg unit_event_flag,
	output reg [1:0] duty_low_bits,
	output reg pwm_mode
);

////////////////////////////////////////////////////////////////////////////
// Mode decode

function is_capture;
	input [3:0] m;
	begin
		is_capture = (m[3:2] == 2'b01);
	end
endfunction

function is_compare;
	input [3:0] m;
	begin
		is_compare = (m[3:2] == 2'b10);
	end
endfunction

function is_pwm;
	input [3:0] m;
	begin
		is_pwm = (m[3:2] == 2'b11);
	end
endfunction

// Special trigger code: timebase reset plus optional conversion
function is_special;
	input [3:0] m;
	begin
		is_special = (m == `MODE_CMP_SPECIAL);
	end
endfunction

// Byte-lane write to one register index
function lane_hit;
	input [7:0] a;
	input [7:0] idx;
	input en;
	begin
		lane_hit = en & (a == idx);
	end
endfunction

reg [7:0] capture_compare_control_reg;
reg [7:0] capture_compare_value_low_reg;
reg [7:0] capture_compare_value_high_reg;
wire [3:0] unit_mode_select;
wire [VALUE_WIDTH-1:0] value;

assign unit_mode_select = capture_compare_control_reg[3:0];
assign value = {capture_compare_value_high_reg,
	capture_compare_value_low_reg};

////////////////////////////////////////////////////////////////////////////
// Pin synchroniser and edge detection

reg pin_meta_reg;
reg pin_sync_reg;
reg pin_last_reg;
wire rise_edge;
wire fall_edge;

always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		pin_meta_reg <= 1'b0;
		pin_sync_reg <= 1'b0;
		pin_last_reg <= 1'b0;
	end else begin
		pin_meta_reg <= unit_event_pin;
		pin_sync_reg <= pin_meta_reg;
		pin_last_reg <= pin_sync_reg;
	end
end

// Two stages; a pin edge reaches the capture logic two clocks late.
// Port writes reach the pin externally, so they arrive here as edges
assign rise_edge = pin_sync_reg & ~pin_last_reg;
assign fall_edge = ~pin_sync_reg & pin_last_reg;

////////////////////////////////////////////////////////////////////////////
// Capture prescaler

reg [3:0] prescale_count_reg;
reg capture_event;
wire prescale_at_4;
wire prescale_at_16;

// Wrap points of the one shared edge counter
assign prescale_at_4 = ((prescale_count_reg & 4'h3) == `PRESCALE_4_LAST);
assign prescale_at_16 = (prescale_count_reg == `PRESCALE_16_LAST);

always @* begin
	case (unit_mode_select)
	`MODE_CAP_FALL: capture_event = fall_edge;
	`MODE_CAP_RISE: capture_event = rise_edge;
	`MODE_CAP_RISE4: capture_event = rise_edge & prescale_at_4;
	`MODE_CAP_RISE16: capture_event = rise_edge & prescale_at_16;
	default: capture_event = 1'b0;
	endcase
end

// Counter keeps its value on a direct prescale switch
always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		prescale_count_reg <= 4'h0;
	end else if (!is_capture(unit_mode_select)) begin
		prescale_count_reg <= 4'h0;
	end else if (rise_edge) begin
		prescale_count_reg <= prescale_count_reg + 4'h1;
	end
end

////////////////////////////////////////////////////////////////////////////
// Compare

wire compare_match;

// Equality only; a count that jumps over the value gives no match
assign compare_match = is_compare(unit_mode_select) &
	(value == timebase_sixteen_count);

reg match_last_reg;

always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		match_last_reg <= 1'b0;
	end else begin
		match_last_reg <= compare_match;
	end
end

// One action per match, even while the count stays equal
wire match_pulse;
assign match_pulse = compare_match & ~match_last_reg;

////////////////////////////////////////////////////////////////////////////
// Avalon-MM slave: one wait cycle, answer on the second edge

// Every access costs two edges: the first only arms the answer.
// Keeps readdata registered at the price of one wait state.
reg access_pending_reg;
wire access;
wire do_write;
wire do_read;
wire lane0;
wire mapped;

assign access = (read | write) & access_pending_reg;
assign do_write = write & access_pending_reg;
assign do_read = read & access_pending_reg;
assign lane0 = byteenable[0];
assign mapped = (address == `CTRL_INDEX) |
	(address == `VALUE_LOW_INDEX) | (address == `VALUE_HIGH_INDEX) |
	(address == `FLAG_INDEX) | (address == `STATUS_INDEX);

always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		access_pending_reg <= 1'b0;
		waitrequest <= 1'b1;
	end else if (access) begin
		access_pending_reg <= 1'b0;
		waitrequest <= 1'b1;
	end else if (read | write) begin
		access_pending_reg <= 1'b1;
		waitrequest <= 1'b0;
	end else begin
		access_pending_reg <= 1'b0;
		waitrequest <= 1'b1;
	end
end

wire ctrl_write;
wire low_write;
wire high_write;
wire flag_write;

// Writes without lane 0 are dropped silently
assign ctrl_write = do_write & lane_hit(address, `CTRL_INDEX, lane0);
assign low_write = do_write & lane_hit(address, `VALUE_LOW_INDEX, lane0);
assign high_write = do_write & lane_hit(address, `VALUE_HIGH_INDEX, lane0);
assign flag_write = do_write & lane_hit(address, `FLAG_INDEX, lane0);

////////////////////////////////////////////////////////////////////////////
// Registers

always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		capture_compare_control_reg <= `CTRL_RESET;
	end else if (ctrl_write) begin
		capture_compare_control_reg <=
			writedata[7:0] & `CTRL_WRITE_MASK;
	end
end

// Capture takes priority over a software write in the same cycle.
// Bytes are not latched against each other: reading both halves while
// captures run may give halves of two different counts.
always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		capture_compare_value_low_reg <= 8'h00;
		capture_compare_value_high_reg <= 8'h00;
	end else if (capture_event) begin
		capture_compare_value_low_reg <= timebase_sixteen_count[7:0];
		capture_compare_value_high_reg <=
			timebase_sixteen_count[15:8];
	end else begin
		if (low_write)
			capture_compare_value_low_reg <= writedata[7:0];
		if (high_write)
			capture_compare_value_high_reg <= writedata[7:0];
	end
end

// Set wins over a software clear in the same cycle
wire flag_set;
assign flag_set = capture_event | match_pulse;

always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		unit_event_flag <= 1'b0;
	end else if (flag_set) begin
		unit_event_flag <= 1'b1;
	end else if (flag_write && !writedata[`FLAG_BIT]) begin
		unit_event_flag <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////
// Compare output latch and triggers

always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		compare_output <= 1'b0;
	end else if (ctrl_write && writedata[7:0] == 8'h00) begin
		compare_output <= 1'b0;
	end else if (match_pulse) begin
		case (unit_mode_select)
		`MODE_CMP_SET: compare_output <= 1'b1;
		`MODE_CMP_CLEAR: compare_output <= 1'b0;
		default: compare_output <= compare_output;
		endcase
	end
end

wire special_match;

// Both triggers share one decode; conversion_start pulses with timebase_reset only while converter_enabled is high
assign special_match = match_pulse & is_special(unit_mode_select);

always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		timebase_reset <= 1'b0;
	end else begin
		timebase_reset <= special_match;
	end
end

// Converter enable is sampled with the match, not latched
always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		conversion_start <= 1'b0;
	end else begin
		conversion_start <= special_match & converter_enabled;
	end
end

always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		pwm_mode <= 1'b0;
	end else begin
		pwm_mode <= is_pwm(unit_mode_select);
	end
end

// Duty bits mean nothing outside PWM, so they show as zero there
always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		duty_low_bits <= 2'b00;
	end else if (is_pwm(unit_mode_select)) begin
		duty_low_bits <= capture_compare_control_reg[5:4];
	end else begin
		duty_low_bits <= 2'b00;
	end
end

////////////////////////////////////////////////////////////////////////////
// Read data

// Unmapped indices read as zero; the response code flags them
reg [7:0] read_byte;

always @* begin
	case (address)
	`CTRL_INDEX: read_byte = capture_compare_control_reg;
	`VALUE_LOW_INDEX: read_byte = capture_compare_value_low_reg;
	`VALUE_HIGH_INDEX: read_byte = capture_compare_value_high_reg;
	`FLAG_INDEX: read_byte = {5'h00, unit_event_flag, 2'b00};
	`STATUS_INDEX: read_byte = {4'h0, compare_output, pin_sync_reg,
		pwm_mode, compare_match};
	default: read_byte = 8'h00;
	endcase
end

always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		readdata <= 32'h0000_0000;
		response <= 2'b00;
	end else if (read | write) begin
		readdata <= read ? {24'h00_0000, read_byte} : 32'h0000_0000;
		response <= mapped ? 2'b00 : 2'b11;
	end else begin
		readdata <= 32'h0000_0000;
		response <= 2'b00;
	end
end

endmodule

// File: tb/capture_compare_checker.sv
// Port checker for the capture/compare unit.
// Assumes one clock domain; attached to the unit by the bind below.
`timescale 1ns/1ns
module capture_compare_checker (
	input wire clk,
	input wire rst_b,
	input wire [7:0] address,
	input wire read,
	input wire write,
	input wire [31:0] readdata,
	input wire waitrequest,
	input wire [1:0] response,
	input wire converter_enabled,
	input wire compare_output,
	input wire timebase_reset,
	input wire conversion_start,
	input wire unit_event_flag,
	input wire [1:0] duty_low_bits,
	input wire pwm_mode
);
	wire done = (read | write) & ~waitrequest;
	wire mapped = address == 8'h0c || (address >= 8'h15 && address <= 8'h18);
	wire ctrl_wr = done & write & (address == 8'h17);
	wire flag_wr = done & write & (address == 8'h0c);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	////////////////////
	a_wait_one_cycle: assert property (
		(read | write) && waitrequest |=> !waitrequest ##1 waitrequest)
		else $error("bus answer not one cycle");
	a_ctrl_top_zero: assert property (
		done && read && address == 8'h17 |-> readdata[31:6] == 0)
		else $error("control top bits not zero");
	a_unmapped_err: assert property (
		done && read && !mapped |-> response == 2'b11 && readdata == 0)
		else $error("unmapped read not refused");
	a_duty_hidden: assert property (
		!pwm_mode |-> duty_low_bits == 2'b00)
		else $error("duty bits outside pwm mode");
	a_trigger_pair: assert property (
		conversion_start |-> timebase_reset && unit_event_flag
		&& $past(converter_enabled))
		else $error("conversion start without trigger");
	a_trigger_pulse: assert property (
		$rose(timebase_reset) |=> !timebase_reset)
		else $error("trigger longer than one cycle");
	a_flag_sticky: assert property (
		unit_event_flag && !flag_wr |=> unit_event_flag)
		else $error("flag dropped by itself");
	a_set_flags: assert property (
		$rose(compare_output) |-> unit_event_flag)
		else $error("output set without flag");
	a_clear_flags: assert property (
		$fell(compare_output) |-> unit_event_flag || $past(ctrl_wr)
		|| $past(ctrl_wr, 2))
		else $error("output cleared without cause");
endmodule
bind capture_compare_unit capture_compare_checker u_capture_compare_checker (
	.clk(clk), .rst_b(rst_b), .address(address), .read(read),
	.write(write), .readdata(readdata), .waitrequest(waitrequest),
	.response(response), .converter_enabled(converter_enabled),
	.compare_output(compare_output), .timebase_reset(timebase_reset),
	.conversion_start(conversion_start), .unit_event_flag(unit_event_flag),
	.duty_low_bits(duty_low_bits), .pwm_mode(pwm_mode));

// File: tb/timebase_pin_model.sv
// Far side of the unit: synchronous timebase count and the event pin.
// Assumes the bench steers the count by hold and the pin by pin_req.
`timescale 1ns/1ns
module timebase_pin_model (
	input wire clk,
	input wire rst_b,
	input wire hold,
	input wire [15:0] hold_value,
	input wire timebase_reset,
	input wire pin_req,
	output reg [15:0] count,
	output reg pin
);
	// Counts on clk only, never asynchronously
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count <= 16'h0000;
			pin <= 1'b0;
		end else begin
			pin <= pin_req;
			if (hold)
				count <= hold_value;
			else if (timebase_reset)
				count <= 16'h0000;
			else
				count <= count + 16'h0001;
		end
	end
endmodule

// File: tb/testbench.sv
// Self-checking bench for the capture/compare unit.
// Assumes the unit, its checker and the timebase/pin model are compiled.
`timescale 1ns/1ns
module testbench;
	reg clk = 0, rst_b = 0, read = 0, write = 0, hold = 1, pin_req = 0;
	reg converter_enabled = 1, conv_seen = 0;
	reg [7:0] address = 0;
	reg [31:0] writedata = 0, rd;
	reg [15:0] hold_value = 0, v;
	reg [1:0] resp;
	wire [31:0] readdata;
	wire [15:0] tb_count;
	wire [1:0] response, duty_low_bits;
	wire waitrequest, pin, compare_output, timebase_reset;
	wire conversion_start, unit_event_flag, pwm_mode;
	integer err_count = 0, cmp_count = 0, i, n, k;
	capture_compare_unit u_capture_compare_unit (.clk(clk), .rst_b(rst_b),
		.address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(4'hf), .readdata(readdata),
		.waitrequest(waitrequest), .response(response),
		.timebase_sixteen_count(tb_count), .unit_event_pin(pin),
		.converter_enabled(converter_enabled),
		.compare_output(compare_output), .timebase_reset(timebase_reset),
		.conversion_start(conversion_start),
		.unit_event_flag(unit_event_flag), .duty_low_bits(duty_low_bits),
		.pwm_mode(pwm_mode));
	timebase_pin_model u_timebase_pin_model (.clk(clk), .rst_b(rst_b),
		.hold(hold), .hold_value(hold_value),
		.timebase_reset(timebase_reset), .pin_req(pin_req),
		.count(tb_count), .pin(pin));
	initial forever #5 clk = ~clk;
	always @(posedge clk) if (conversion_start === 1'b1) conv_seen <= 1'b1;
	////////////////////
	task check(input [31:0] seen, input [31:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (seen !== exp) begin
				err_count = err_count + 1;
				$display("ERROR %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task bus(input wr, input [7:0] a, input [7:0] d);
		begin
			@(posedge clk);
			address <= a;
			writedata <= {24'h0, d};
			read <= !wr;
			write <= wr;
			@(posedge clk);
			while (waitrequest !== 1'b0) @(posedge clk);
			rd = readdata;
			resp = response;
			read <= 1'b0;
			write <= 1'b0;
		end
	endtask
	task pulse;
		begin
			@(posedge clk);
			pin_req <= 1'b1;
			repeat (4) @(posedge clk);
			pin_req <= 1'b0;
			repeat (4) @(posedge clk);
		end
	endtask
	task tally_and_finish;
		begin
			if (err_count == 0 && cmp_count > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	////////////////////
	initial begin
		#100000;
		err_count = err_count + 1;
		tally_and_finish;
	end
	initial begin
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		bus(0, 8'h17, 0);
		check(rd, 32'h00);
		bus(1, 8'h17, 8'hff);
		bus(0, 8'h17, 0);
		check(rd, 32'h3f);
		check({pwm_mode, duty_low_bits}, 3'b111);
		bus(1, 8'h17, 8'h38);
		repeat (2) @(posedge clk);
		check({pwm_mode, duty_low_bits}, 3'b000);
		bus(1, 8'h15, 8'h5a);
		bus(1, 8'h16, 8'ha5);
		bus(0, 8'h15, 0);
		check(rd, 32'h5a);
		bus(0, 8'h16, 0);
		check(rd, 32'ha5);
		bus(0, 8'h40, 0);
		check(resp, 2'b11);
		check(rd, 32'h0);
		// Modes 8, a, 9, b, 8 and the pin level each must leave
		v = 16'h0300;
		hold <= 1'b0;
		for (i = 0; i < 5; i = i + 1) begin
			v = v + 16'h0101;
			// High byte first so no passing value meets the count
			bus(1, 8'h16, v[15:8]);
			bus(1, 8'h15, v[7:0]);
			bus(1, 8'h17, {4'h0, 20'h8a9b8 >> (16 - 4 * i)} & 8'h0f);
			bus(1, 8'h0c, 0);
			bus(0, 8'h0c, 0);
			check(rd[2], 0);
			@(posedge clk);
			hold <= 1'b1;
			hold_value <= v - 16'h0004;
			@(posedge clk);
			hold <= 1'b0;
			n = 0;
			while (unit_event_flag !== 1'b1 && n < 20) begin
				@(posedge clk);
				n = n + 1;
			end
			check(unit_event_flag, 1);
			check(compare_output, (5'b11001 >> (4 - i)) & 1);
			repeat (3) @(posedge clk);
			if (i == 3)
				check(tb_count < v, 1);
		end
		check(conv_seen, 1);
		bus(1, 8'h17, 0);
		repeat (2) @(posedge clk);
		check(compare_output, 0);
		// Capture modes 4 to 7 with edge counts 1, 1, 4, 16
		hold <= 1'b1;
		for (i = 0; i < 4; i = i + 1) begin
			k = i < 2 ? 1 : (i == 2 ? 4 : 16);
			bus(1, 8'h17, 0);
			bus(1, 8'h17, 8'h04 + i[7:0]);
			bus(1, 8'h0c, 0);
			hold_value <= 16'h1000 + i[15:0];
			repeat (k - 1) pulse;
			bus(0, 8'h0c, 0);
			check(rd[2], 0);
			pulse;
			hold_value <= 16'h2000 + i[15:0];
			repeat (k) pulse;
			bus(0, 8'h15, 0);
			v[7:0] = rd[7:0];
			bus(0, 8'h16, 0);
			check({rd[7:0], v[7:0]}, 16'h2000 + i);
			bus(0, 8'h0c, 0);
			check(rd[2], 1);
		end
		tally_and_finish;
	end
endmodule
